// ===== core/cmbi_pkg.sv
// Constants and types of the memory bus interface
// How it works
// - Coefficient read bus 32 bits, others 16
// - Coefficient bus reads internal memory only
// - External coefficient address raises bus error
// - Quad read uses all three read buses
// - Dual read uses both, single primary only
// - 23-bit read addresses, data returned per bus
// - Each read address bus pairs its data
// - Program data arrives four bytes per fetch
// - Program address is 24-bit byte address
// - Two 16-bit write buses carry unit data
// - Dual write uses both, single primary only
// - 23-bit write addresses paired with data
// - Data addresses come from address generator
// - All memory traffic passes this one unit
// - Queue takes four bytes, decoder 1-8
// - Instruction constants extracted and forwarded
// - Branch empties the instruction queue
// - Repeat loops keep loaded code held
// - Queue holds 128 bytes, decoder sees 8
package cmbi_pkg;
   // ==========================================
   // Bus widths
   localparam int unsigned DATA_W = 16;
   localparam int unsigned COEF_W = 32;
   localparam int unsigned DADDR_W = 23;
   localparam int unsigned PADDR_W = 24;
   localparam int unsigned PROG_W = 32;
   // ==========================================
   // Last internal word address (plain default)
   localparam logic [22:0] INT_MEM_LAST_DEF = 23'h00FFFF;
   // ==========================================
   // Queue sizing
   localparam logic [8:0] IBQ_BYTES = 9'h080;
   localparam logic [8:0] FETCH_BYTES = 9'h004;
   localparam logic [8:0] FETCH_ROOM = IBQ_BYTES - FETCH_BYTES;
   localparam logic [3:0] DEC_BYTES = 4'h8;
   localparam logic [1:0] MAX_INFLIGHT = 2'h2;
   localparam logic [23:0] FETCH_STEP = 24'h000004;
   // ==========================================
   // Read kinds, constant destinations
   typedef enum logic [1:0] {RD_SINGLE, RD_DUAL, RD_COEF, RD_QUAD} cmbi_rd_kind_t;
   typedef enum logic [1:0] {IMM_P, IMM_A, IMM_D} cmbi_imm_dest_t;
endpackage

// ===== core/cmbi_queue_mem.sv
// Instruction queue bytes with a registered window
`timescale 1ns/1ps
module cmbi_queue_mem (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic [4:0] i_wr_word,
   input wire logic [31:0] i_wr_data,
   input wire logic [6:0] i_rd_ptr,
   output logic [63:0] o_rd_data
);
   typedef struct packed {
      logic [127:0][7:0] bytes;
      logic [63:0] rd_data;
   } cmbi_mem_state_t;

   cmbi_mem_state_t state_reg;
   cmbi_mem_state_t state_next;

   // Window shows old bytes; writes are credited a cycle late
   always_comb begin
      state_next = state_reg;
      if (i_wr_en) begin
         for (int k = 0; k < 4; k++) begin
            state_next.bytes[{i_wr_word, 2'(k)}] = i_wr_data[31 - 8 * k -: 8];
         end
      end
      for (int k = 0; k < 8; k++) begin
         state_next.rd_data[8 * k +: 8] = state_reg.bytes[7'(i_rd_ptr + 7'(k))];
      end
   end

   // State register
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_rd_data = state_reg.rd_data;
endmodule

// ===== core/cmbi_top.sv
// Memory interface unit: data buses, program fetch, instruction queue
`timescale 1ns/1ps
module cmbi_top #(
   parameter logic [22:0] INT_LIMIT = cmbi_pkg::INT_MEM_LAST_DEF
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_rd_req,
   input cmbi_pkg::cmbi_rd_kind_t i_rd_kind,
   input wire logic i_rd_io,
   input wire logic [22:0] i_agu_primary_rd_addr,
   input wire logic [22:0] i_agu_second_rd_addr,
   input wire logic [22:0] i_agu_coef_rd_addr,
   output logic o_rd_busy,
   output logic [22:0] o_primary_read_addr_bus,
   output logic [22:0] o_second_read_addr_bus,
   output logic [22:0] o_coef_read_addr_bus,
   output logic o_primary_rd_en,
   output logic o_second_rd_en,
   output logic o_coef_rd_en,
   output logic o_rd_io,
   input wire logic i_mem_rd_valid,
   input wire logic [15:0] i_mem_primary_data,
   input wire logic [15:0] i_mem_second_data,
   input wire logic [31:0] i_mem_coef_data,
   output logic [15:0] o_primary_read_data_bus,
   output logic [15:0] o_second_read_data_bus,
   output logic [31:0] o_coef_read_data_bus,
   output logic o_rd_done,
   output logic o_bus_error_irq,
   input wire logic i_wr_req,
   input wire logic i_wr_dual,
   input wire logic i_wr_io,
   input wire logic [22:0] i_agu_primary_wr_addr,
   input wire logic [22:0] i_agu_second_wr_addr,
   input wire logic [15:0] i_unit_primary_wr_data,
   input wire logic [15:0] i_unit_second_wr_data,
   output logic [22:0] o_primary_write_addr_bus,
   output logic [22:0] o_second_write_addr_bus,
   output logic [15:0] o_primary_write_data_bus,
   output logic [15:0] o_second_write_data_bus,
   output logic o_primary_wr_en,
   output logic o_second_wr_en,
   output logic o_wr_io,
   input wire logic i_branch,
   input wire logic [23:0] i_branch_addr,
   output logic [23:0] o_prog_read_addr_bus,
   output logic o_prog_rd_en,
   input wire logic i_prog_rd_valid,
   input wire logic [31:0] i_prog_read_data_bus,
   output logic [63:0] o_dec_bytes,
   output logic [3:0] o_dec_avail,
   input wire logic [3:0] i_dec_consume,
   input wire logic i_repeat_start,
   input wire logic i_repeat_end,
   input wire logic i_loop_back,
   input wire logic i_imm_req,
   input wire logic [2:0] i_imm_pos,
   input wire logic [1:0] i_imm_size,
   input cmbi_pkg::cmbi_imm_dest_t i_imm_dest,
   output logic [31:0] o_imm_value,
   output logic o_imm_p_valid,
   output logic o_imm_a_valid,
   output logic o_imm_d_valid
);
   typedef enum logic {st_rd_idle, st_rd_wait} cmbi_rd_state_t;

   typedef struct packed {
      cmbi_rd_state_t rd_state;
      logic rd_busy;
      logic [22:0] p_ra;
      logic [22:0] s_ra;
      logic [22:0] c_ra;
      logic p_re;
      logic s_re;
      logic c_re;
      logic rd_io;
      logic [2:0] lanes;
      logic [15:0] p_rd;
      logic [15:0] s_rd;
      logic [31:0] c_rd;
      logic rd_done;
      logic bus_err;
      logic [22:0] p_wa;
      logic [22:0] s_wa;
      logic [15:0] p_wd;
      logic [15:0] s_wd;
      logic p_we;
      logic s_we;
      logic wr_io;
      logic [23:0] f_addr;
      logic [23:0] pr_addr;
      logic pr_en;
      logic [1:0] inflight;
      logic [1:0] drop;
      logic [1:0] skip;
      logic [4:0] wr_word;
      logic [6:0] rd_ptr;
      logic [7:0] count;
      logic [2:0] credit;
      logic [7:0] keep;
      logic [6:0] loop_start;
      logic rep_on;
      logic [3:0] avail;
      logic [31:0] imm_val;
      logic imm_p;
      logic imm_a;
      logic imm_d;
   } cmbi_top_state_t;

   cmbi_top_state_t state_reg;
   cmbi_top_state_t state_next;
   logic mem_we;
   logic [63:0] mem_rd_data;

   // ==========================================
   // Next-state logic
   always_comb begin
      logic use_p;
      logic use_s;
      logic use_c;
      logic coef_bad;
      logic keep_word;
      logic [1:0] inflight_after;
      logic [3:0] cons;
      logic [7:0] count_n;
      logic [7:0] keep_n;
      logic [2:0] credit_n;
      logic [8:0] used;
      logic [2:0] idx;
      logic [31:0] val;
      use_p = 1'b0;
      use_s = 1'b0;
      use_c = 1'b0;
      coef_bad = 1'b0;
      keep_word = 1'b0;
      inflight_after = 2'h0;
      cons = 4'h0;
      count_n = 8'h00;
      keep_n = 8'h00;
      credit_n = 3'h0;
      used = 9'h000;
      idx = 3'h0;
      val = 32'h0;
      state_next = state_reg;
      state_next.rd_done = 1'b0;
      state_next.bus_err = 1'b0;
      state_next.p_re = 1'b0;
      state_next.s_re = 1'b0;
      state_next.c_re = 1'b0;
      state_next.p_we = 1'b0;
      state_next.s_we = 1'b0;
      state_next.pr_en = 1'b0;
      state_next.imm_p = 1'b0;
      state_next.imm_a = 1'b0;
      state_next.imm_d = 1'b0;

      // Read path; requests while busy are ignored
      case (state_reg.rd_state)
         st_rd_idle: begin
            if (i_rd_req) begin
               use_c = (i_rd_kind == cmbi_pkg::RD_COEF) || (i_rd_kind == cmbi_pkg::RD_QUAD);
               use_s = (i_rd_kind == cmbi_pkg::RD_DUAL) || (i_rd_kind == cmbi_pkg::RD_QUAD);
               use_p = (i_rd_kind != cmbi_pkg::RD_COEF);
               coef_bad = use_c && (i_rd_io || (i_agu_coef_rd_addr > INT_LIMIT));
               if (coef_bad) begin
                  state_next.bus_err = 1'b1;
                  state_next.rd_done = 1'b1;
                  state_next.p_rd = 16'h0000;
                  state_next.s_rd = 16'h0000;
                  state_next.c_rd = 32'h0;
               end else begin
                  state_next.p_ra = i_agu_primary_rd_addr;
                  state_next.s_ra = i_agu_second_rd_addr;
                  state_next.c_ra = i_agu_coef_rd_addr;
                  state_next.p_re = use_p;
                  state_next.s_re = use_s;
                  state_next.c_re = use_c;
                  state_next.rd_io = i_rd_io;
                  state_next.lanes = {use_c, use_s, use_p};
                  state_next.rd_state = st_rd_wait;
                  state_next.rd_busy = 1'b1;
               end
            end
         end
         st_rd_wait: begin
            if (i_mem_rd_valid) begin
               state_next.p_rd = state_reg.lanes[0] ? i_mem_primary_data : 16'h0000;
               state_next.s_rd = state_reg.lanes[1] ? i_mem_second_data : 16'h0000;
               state_next.c_rd = state_reg.lanes[2] ? i_mem_coef_data : 32'h0;
               state_next.rd_done = 1'b1;
               state_next.rd_busy = 1'b0;
               state_next.rd_state = st_rd_idle;
            end
         end
         default: begin
            state_next.rd_state = st_rd_idle;
            state_next.rd_busy = 1'b0;
         end
      endcase

      if (i_wr_req) begin
         state_next.p_wa = i_agu_primary_wr_addr;
         state_next.p_wd = i_unit_primary_wr_data;
         state_next.p_we = 1'b1;
         state_next.wr_io = i_wr_io;
         if (i_wr_dual) begin
            state_next.s_wa = i_agu_second_wr_addr;
            state_next.s_wd = i_unit_second_wr_data;
            state_next.s_we = 1'b1;
         end
      end

      // Fetch bookkeeping; in-flight words dropped at branch
      inflight_after = 2'(state_reg.inflight - {1'b0, i_prog_rd_valid});
      if (i_prog_rd_valid && (state_reg.drop != 2'h0)) begin
         state_next.drop = 2'(state_reg.drop - 2'h1);
      end
      keep_word = i_prog_rd_valid && (state_reg.drop == 2'h0) && !i_branch;
      cons = (i_dec_consume > state_reg.avail) ? state_reg.avail : i_dec_consume;

      if (i_branch) begin
         state_next.rd_ptr = {5'h00, i_branch_addr[1:0]};
         state_next.wr_word = 5'h00;
         state_next.count = 8'h00;
         state_next.credit = 3'h0;
         state_next.keep = 8'h00;
         state_next.rep_on = 1'b0;
         state_next.skip = i_branch_addr[1:0];
         state_next.f_addr = {i_branch_addr[23:2], 2'b00};
         state_next.drop = inflight_after;
         state_next.inflight = inflight_after;
         state_next.avail = 4'h0;
      end else begin
         // Retire 0 to 8 decoded bytes
         count_n = 8'(state_reg.count + {5'h00, state_reg.credit} - {4'h0, cons});
         keep_n = state_reg.rep_on ? 8'(state_reg.keep + {4'h0, cons}) : 8'h00;
         state_next.rd_ptr = 7'(state_reg.rd_ptr + {3'h0, cons});
         credit_n = 3'h0;
         if (keep_word) begin
            credit_n = 3'(3'h4 - {1'b0, state_reg.skip});
            state_next.wr_word = 5'(state_reg.wr_word + 5'h01);
            state_next.skip = 2'h0;
         end
         if (i_repeat_start) begin
            state_next.rep_on = 1'b1;
            state_next.loop_start = state_reg.rd_ptr;
            keep_n = {4'h0, cons};
         end else if (i_repeat_end) begin
            state_next.rep_on = 1'b0;
            keep_n = 8'h00;
         end else if (i_loop_back && state_reg.rep_on) begin
            state_next.rd_ptr = state_reg.loop_start;
            count_n = 8'(count_n + keep_n);
            keep_n = 8'h00;
         end
         state_next.count = count_n;
         state_next.keep = keep_n;
         state_next.credit = credit_n;
         used = 9'({1'b0, count_n} + {6'h00, credit_n} + {1'b0, keep_n} + {5'h00, inflight_after, 2'b00});
         if ((inflight_after < cmbi_pkg::MAX_INFLIGHT) && (used <= cmbi_pkg::FETCH_ROOM)) begin
            state_next.pr_en = 1'b1;
            state_next.pr_addr = state_reg.f_addr;
            state_next.f_addr = 24'(state_reg.f_addr + cmbi_pkg::FETCH_STEP);
            state_next.inflight = 2'(inflight_after + 2'h1);
         end else begin
            state_next.inflight = inflight_after;
         end
         state_next.avail = (count_n >= {4'h0, cmbi_pkg::DEC_BYTES}) ? cmbi_pkg::DEC_BYTES : count_n[3:0];
      end

      // Extract constant, first byte most significant
      if (i_imm_req) begin
         for (int k = 0; k < 4; k++) begin
            idx = 3'(i_imm_pos + 3'(k));
            if (k <= int'(i_imm_size)) begin
               val = {val[23:0], mem_rd_data[8 * idx +: 8]};
            end
         end
         state_next.imm_val = val;
         state_next.imm_p = (i_imm_dest == cmbi_pkg::IMM_P);
         state_next.imm_a = (i_imm_dest == cmbi_pkg::IMM_A);
         state_next.imm_d = (i_imm_dest == cmbi_pkg::IMM_D);
      end
   end

   // State register
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // Queue storage; window follows next pointer
   assign mem_we = i_prog_rd_valid && (state_reg.drop == 2'h0) && !i_branch;

   cmbi_queue_mem u_queue (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_wr_en(mem_we),
      .i_wr_word(state_reg.wr_word),
      .i_wr_data(i_prog_read_data_bus),
      .i_rd_ptr(state_next.rd_ptr),
      .o_rd_data(mem_rd_data)
   );

   // ==========================================
   // Outputs from the state register and the queue window
   assign o_rd_busy = state_reg.rd_busy;
   assign o_primary_read_addr_bus = state_reg.p_ra;
   assign o_second_read_addr_bus = state_reg.s_ra;
   assign o_coef_read_addr_bus = state_reg.c_ra;
   assign o_primary_rd_en = state_reg.p_re;
   assign o_second_rd_en = state_reg.s_re;
   assign o_coef_rd_en = state_reg.c_re;
   assign o_rd_io = state_reg.rd_io;
   assign o_primary_read_data_bus = state_reg.p_rd;
   assign o_second_read_data_bus = state_reg.s_rd;
   assign o_coef_read_data_bus = state_reg.c_rd;
   assign o_rd_done = state_reg.rd_done;
   assign o_bus_error_irq = state_reg.bus_err;
   assign o_primary_write_addr_bus = state_reg.p_wa;
   assign o_second_write_addr_bus = state_reg.s_wa;
   assign o_primary_write_data_bus = state_reg.p_wd;
   assign o_second_write_data_bus = state_reg.s_wd;
   assign o_primary_wr_en = state_reg.p_we;
   assign o_second_wr_en = state_reg.s_we;
   assign o_wr_io = state_reg.wr_io;
   assign o_prog_read_addr_bus = state_reg.pr_addr;
   assign o_prog_rd_en = state_reg.pr_en;
   assign o_dec_bytes = mem_rd_data;
   assign o_dec_avail = state_reg.avail;
   assign o_imm_value = state_reg.imm_val;
   assign o_imm_p_valid = state_reg.imm_p;
   assign o_imm_a_valid = state_reg.imm_a;
   assign o_imm_d_valid = state_reg.imm_d;

   // ==========================================
   // Checks
   default clocking cb_sys @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   logic [8:0] q_fill;
   logic rd_take;
   assign q_fill = {1'b0, state_reg.count} + {6'h00, state_reg.credit} + {1'b0, state_reg.keep};
   assign rd_take = i_rd_req && (state_reg.rd_state == st_rd_idle);

   a_coef_ext_err: assert property (
      rd_take && i_rd_kind[1] && (i_agu_coef_rd_addr > INT_LIMIT)
      |=> o_bus_error_irq && o_rd_done && !o_coef_rd_en && !o_rd_busy)
      else $error("no bus error on external coef");
   a_err_zero_data: assert property (
      o_bus_error_irq |-> $past(rd_take) && o_rd_done && (o_coef_read_data_bus == 32'h0)
      && (o_primary_read_data_bus == 16'h0000) && (o_second_read_data_bus == 16'h0000))
      else $error("bad bus error pulse");
   a_coef_internal: assert property (
      o_coef_rd_en |-> (o_coef_read_addr_bus <= INT_LIMIT) && !o_rd_io)
      else $error("coef bus went external");
   a_single_primary: assert property (
      rd_take && (i_rd_kind == cmbi_pkg::RD_SINGLE) |=> o_primary_rd_en && !o_second_rd_en && !o_coef_rd_en)
      else $error("single read lanes wrong");
   a_quad_lanes: assert property (
      rd_take && (i_rd_kind == cmbi_pkg::RD_QUAD) && !i_rd_io && (i_agu_coef_rd_addr <= INT_LIMIT)
      |=> o_primary_rd_en && o_second_rd_en && o_coef_rd_en)
      else $error("quad read lanes wrong");
   a_addr_pairing: assert property (
      o_second_rd_en |-> (o_second_read_addr_bus == $past(i_agu_second_rd_addr))
      && (o_primary_read_addr_bus == $past(i_agu_primary_rd_addr)))
      else $error("read address mismatch");
   a_read_return: assert property (
      (state_reg.rd_state == st_rd_wait) && i_mem_rd_valid && state_reg.lanes[2]
      |=> o_rd_done && (o_coef_read_data_bus == $past(i_mem_coef_data)) ##1 (!o_rd_done || o_bus_error_irq))
      else $error("read data mismatch");
   a_wr_lanes: assert property (
      i_wr_req && !i_wr_dual |=> o_primary_wr_en && !o_second_wr_en)
      else $error("single write lanes wrong");
   a_wr_values: assert property (
      i_wr_req && i_wr_dual |=> o_second_wr_en && (o_second_write_addr_bus == $past(i_agu_second_wr_addr))
      && (o_primary_write_data_bus == $past(i_unit_primary_wr_data)))
      else $error("write mismatch");
   a_flush_empty: assert property (
      i_branch |=> (o_dec_avail == 4'h0) ##1 (o_dec_avail == 4'h0))
      else $error("queue not flushed");
   a_fetch_seq: assert property (
      o_prog_rd_en && $past(o_prog_rd_en) |-> o_prog_read_addr_bus == 24'($past(o_prog_read_addr_bus) + 24'h000004))
      else $error("fetch not sequential");
   a_queue_cap: assert property (
      q_fill <= cmbi_pkg::IBQ_BYTES && o_dec_avail <= cmbi_pkg::DEC_BYTES)
      else $error("queue overfilled");
   a_loop_rewind: assert property (
      i_loop_back && state_reg.rep_on && !i_branch && !i_repeat_start && !i_repeat_end
      |=> state_reg.rd_ptr == $past(state_reg.loop_start))
      else $error("loop rewind wrong");
   a_imm_route: assert property (
      i_imm_req && (i_imm_dest == cmbi_pkg::IMM_A) |=> o_imm_a_valid && !o_imm_p_valid && !o_imm_d_valid)
      else $error("constant misrouted");

   c_bus_error: cover property (o_bus_error_irq);
   c_quad_read: cover property (o_primary_rd_en && o_second_rd_en && o_coef_rd_en);
   c_dual_write: cover property (o_primary_wr_en && o_second_wr_en);
   c_loop_back: cover property (i_loop_back && state_reg.rep_on ##1 o_dec_avail != 4'h0);
endmodule

// ===== tb/cmbi_mem_model.sv
// Memory partner for data reads and fetches
`timescale 1ns/1ps
module cmbi_mem_model (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_slow,
   input wire logic i_p_en,
   input wire logic i_s_en,
   input wire logic i_c_en,
   input wire logic [22:0] i_p_addr,
   input wire logic [22:0] i_s_addr,
   input wire logic [22:0] i_c_addr,
   output logic o_rd_valid,
   output logic [15:0] o_p_data,
   output logic [15:0] o_s_data,
   output logic [31:0] o_c_data,
   input wire logic i_prog_en,
   input wire logic [23:0] i_prog_addr,
   output logic o_prog_valid,
   output logic [31:0] o_prog_data
);
   logic [22:0] pa_reg, sa_reg, ca_reg;
   logic [23:0] ga_reg;
   logic [7:0] gb;
   logic [1:0] wait_reg;
   logic pend_reg;
   // ========
   // Slow mode adds two wait cycles
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pend_reg <= 1'b0;
         wait_reg <= 2'h0;
         o_rd_valid <= 1'b0;
         o_prog_valid <= 1'b0;
      end else begin
         o_rd_valid <= pend_reg && wait_reg == 2'h0;
         o_prog_valid <= i_prog_en;
         if (i_prog_en) ga_reg <= i_prog_addr;
         if (i_p_en | i_s_en | i_c_en) begin
            pend_reg <= 1'b1;
            wait_reg <= i_slow ? 2'h2 : 2'h0;
            pa_reg <= i_p_addr;
            sa_reg <= i_s_addr;
            ca_reg <= i_c_addr;
         end else if (wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
         end else begin
            pend_reg <= 1'b0;
         end
      end
   end
   // Lanes invert outside valid cycles so stale data fails
   assign gb = ga_reg[7:0];
   assign o_p_data = {16{~o_rd_valid}} ^ pa_reg[15:0] ^ 16'hA5C3;
   assign o_s_data = {16{~o_rd_valid}} ^ sa_reg[15:0] ^ 16'hA5C3;
   assign o_c_data = {32{~o_rd_valid}} ^ {ca_reg[15:0], ~ca_reg[15:0]};
   assign o_prog_data = {32{~o_prog_valid}} ^ {gb, gb + 8'h01, gb + 8'h02, gb + 8'h03};
endmodule

// ===== tb/tb_top.sv
// Self-checking bench
`timescale 1ns/1ps
module tb_top;
   localparam logic [22:0] LIM = 23'h003FFF;
   logic i_clk_sys, i_rst, i_rd_req, i_rd_io, o_rd_busy, o_primary_rd_en, o_second_rd_en, o_coef_rd_en, o_rd_io;
   logic i_mem_rd_valid, o_rd_done, o_bus_error_irq, i_wr_req, i_wr_dual, i_wr_io, o_primary_wr_en, o_second_wr_en;
   logic o_wr_io, i_branch, o_prog_rd_en, i_prog_rd_valid, i_repeat_start, i_repeat_end, i_loop_back, i_imm_req;
   logic o_imm_p_valid, o_imm_a_valid, o_imm_d_valid, mem_slow;
   cmbi_pkg::cmbi_rd_kind_t i_rd_kind;
   cmbi_pkg::cmbi_imm_dest_t i_imm_dest;
   logic [22:0] i_agu_primary_rd_addr, i_agu_second_rd_addr, i_agu_coef_rd_addr, o_primary_read_addr_bus;
   logic [22:0] o_second_read_addr_bus, o_coef_read_addr_bus, i_agu_primary_wr_addr, i_agu_second_wr_addr;
   logic [22:0] o_primary_write_addr_bus, o_second_write_addr_bus;
   logic [15:0] i_mem_primary_data, i_mem_second_data, o_primary_read_data_bus, o_second_read_data_bus, lf;
   logic [15:0] i_unit_primary_wr_data, i_unit_second_wr_data, o_primary_write_data_bus, o_second_write_data_bus;
   logic [31:0] i_mem_coef_data, o_coef_read_data_bus, i_prog_read_data_bus, o_imm_value;
   logic [23:0] i_branch_addr, o_prog_read_addr_bus;
   logic [63:0] o_dec_bytes;
   logic [3:0] o_dec_avail, i_dec_consume;
   logic [2:0] i_imm_pos;
   logic [1:0] i_imm_size;
   logic [7:0] sum;
   logic [64:0] exp_q[$];
   int miscompares, checks_done, cyc;
   cmbi_top #(.INT_LIMIT(LIM)) cmbi_top_inst (.i_clk_sys, .i_rst, .i_rd_req, .i_rd_kind, .i_rd_io,
      .i_agu_primary_rd_addr, .i_agu_second_rd_addr, .i_agu_coef_rd_addr, .o_rd_busy, .o_primary_read_addr_bus,
      .o_second_read_addr_bus, .o_coef_read_addr_bus, .o_primary_rd_en, .o_second_rd_en, .o_coef_rd_en, .o_rd_io,
      .i_mem_rd_valid, .i_mem_primary_data, .i_mem_second_data, .i_mem_coef_data, .o_primary_read_data_bus,
      .o_second_read_data_bus, .o_coef_read_data_bus, .o_rd_done, .o_bus_error_irq, .i_wr_req, .i_wr_dual, .i_wr_io,
      .i_agu_primary_wr_addr, .i_agu_second_wr_addr, .i_unit_primary_wr_data, .i_unit_second_wr_data,
      .o_primary_write_addr_bus, .o_second_write_addr_bus, .o_primary_write_data_bus, .o_second_write_data_bus,
      .o_primary_wr_en, .o_second_wr_en, .o_wr_io, .i_branch, .i_branch_addr, .o_prog_read_addr_bus, .o_prog_rd_en,
      .i_prog_rd_valid, .i_prog_read_data_bus, .o_dec_bytes, .o_dec_avail, .i_dec_consume, .i_repeat_start,
      .i_repeat_end, .i_loop_back, .i_imm_req, .i_imm_pos, .i_imm_size, .i_imm_dest, .o_imm_value, .o_imm_p_valid,
      .o_imm_a_valid, .o_imm_d_valid);
   cmbi_mem_model cmbi_mem_model_inst (.i_clk_sys, .i_rst, .i_slow(mem_slow), .i_p_en(o_primary_rd_en),
      .i_s_en(o_second_rd_en), .i_c_en(o_coef_rd_en), .i_p_addr(o_primary_read_addr_bus),
      .i_s_addr(o_second_read_addr_bus), .i_c_addr(o_coef_read_addr_bus), .o_rd_valid(i_mem_rd_valid),
      .o_p_data(i_mem_primary_data), .o_s_data(i_mem_second_data), .o_c_data(i_mem_coef_data),
      .i_prog_en(o_prog_rd_en), .i_prog_addr(o_prog_read_addr_bus), .o_prog_valid(i_prog_rd_valid),
      .o_prog_data(i_prog_read_data_bus));
   // ========
   // Helpers
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [64:0] got, input logic [64:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
      if (miscompares == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   // One read; unused or faulting lanes expect zero
   task automatic rd(input cmbi_pkg::cmbi_rd_kind_t k, input logic io, input logic [22:0] cadr);
      logic uc, err;
      uc = k[1];
      err = uc && (io || cadr > LIM);
      i_rd_req = 1'b1;
      i_rd_kind = k;
      i_rd_io = io;
      i_agu_primary_rd_addr = {7'h00, lf};
      i_agu_second_rd_addr = {7'h00, ~lf};
      i_agu_coef_rd_addr = cadr;
      exp_q.push_back({err, (k != cmbi_pkg::RD_COEF && !err) ? lf ^ 16'hA5C3 : 16'h0000,
         (k[0] && !err) ? ~lf ^ 16'hA5C3 : 16'h0000, (uc && !err) ? {cadr[15:0], ~cadr[15:0]} : 32'h0});
      lf = nx(lf);
      tick(1);
      i_rd_req = 1'b0;
      repeat (20) begin
         if (o_rd_done === 1'b1) break;
         tick(1);
      end
   endtask
   // ========
   // Clock, timeout, watcher
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc > 3000) begin
         miscompares++;
         conclude();
      end
      if (o_rd_done === 1'b1) chk({o_bus_error_irq, o_primary_read_data_bus, o_second_read_data_bus,
         o_coef_read_data_bus}, exp_q.pop_front());
   end
   // ========
   // Main sequence
   initial begin
      {i_rd_req, i_rd_io, i_wr_req, i_wr_dual, i_wr_io, i_branch, i_repeat_start, i_repeat_end, i_loop_back} = '0;
      {i_agu_primary_rd_addr, i_agu_second_rd_addr, i_agu_coef_rd_addr, i_agu_primary_wr_addr} = '0;
      {i_agu_second_wr_addr, i_unit_primary_wr_data, i_unit_second_wr_data, i_branch_addr} = '0;
      {i_dec_consume, i_imm_req, i_imm_pos, i_imm_size, mem_slow} = '0;
      i_rd_kind = cmbi_pkg::RD_SINGLE;
      i_imm_dest = cmbi_pkg::IMM_P;
      i_rst = 1'b1;
      lf = 16'h000B;
      tick(10);
      i_rst = 1'b0;
      for (int b = 0; b < 2; b++) begin
         i_branch = 1'b1;
         i_branch_addr = b ? 24'h000200 : 24'h000102;
         tick(1);
         i_branch = 1'b0;
         chk({o_dec_avail, o_prog_read_addr_bus[1:0]}, 6'h00);
         tick(8);
         chk({o_dec_avail, o_dec_bytes[31:0]}, {4'h8, b ? 32'h03020100 : 32'h05040302});
      end
      i_branch = 1'b1;
      i_branch_addr = 24'h000102;
      tick(1);
      i_branch = 1'b0;
      tick(8);
      i_imm_req = 1'b1;
      i_imm_pos = 3'h1;
      i_imm_size = 2'h2;
      for (int d = 0; d < 3; d++) begin
         i_imm_dest = cmbi_pkg::cmbi_imm_dest_t'(d);
         tick(1);
         chk({o_imm_d_valid, o_imm_a_valid, o_imm_p_valid, o_imm_value}, {3'(1 << d), 32'h00030405});
      end
      i_imm_req = 1'b0;
      sum = 8'h02;
      repeat (30) begin
         i_dec_consume = {2'b00, lf[1:0]};
         sum = sum + {6'h00, lf[1:0]};
         lf = nx(lf);
         tick(1);
      end
      i_dec_consume = 4'h0;
      tick(4);
      chk({o_dec_avail, o_dec_bytes[7:0]}, {4'h8, sum});
      for (int k = 0; k < 8; k++) begin
         mem_slow = k[2];
         rd(cmbi_pkg::cmbi_rd_kind_t'(k), 1'b0, {9'h000, lf[13:0]});
      end
      rd(cmbi_pkg::RD_COEF, 1'b0, LIM);
      rd(cmbi_pkg::RD_QUAD, 1'b0, LIM + 23'h000001);
      rd(cmbi_pkg::RD_COEF, 1'b1, 23'h000010);
      rd(cmbi_pkg::RD_SINGLE, 1'b1, 23'h000000);
      for (int w = 0; w < 4; w++) begin
         i_wr_req = 1'b1;
         i_wr_dual = w[0];
         i_wr_io = lf[0];
         i_agu_primary_wr_addr = {7'h00, lf};
         i_agu_second_wr_addr = {7'h00, ~lf};
         i_unit_primary_wr_data = ~lf;
         i_unit_second_wr_data = lf ^ 16'h3C3C;
         tick(1);
         chk({o_primary_wr_en, o_second_wr_en, o_wr_io, o_primary_write_addr_bus, o_primary_write_data_bus},
            {1'b1, w[0], lf[0], 7'h00, lf, ~lf});
         if (w[0]) chk({o_second_write_addr_bus, o_second_write_data_bus}, {7'h00, ~lf, lf ^ 16'h3C3C});
         lf = nx(lf);
      end
      i_wr_req = 1'b0;
      tick(4);
      conclude();
   end
endmodule
